// >>> dv/abc_mcu_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// processor core as bus master on the register port
// ---------------------------------------------------------------
module abc_mcu_model (
  // clock
  input  wire logic        CLK,
  // write channels
  output logic [9:0]       AWADDR,
  output logic             AWVALID,
  input  wire logic        AWREADY,
  output logic [31:0]      WDATA,
  output logic [3:0]       WSTRB,
  output logic             WVALID,
  input  wire logic        WREADY,
  input  wire logic [1:0]  BRESP,
  input  wire logic        BVALID,
  output logic             BREADY,
  // read channels
  output logic [9:0]       ARADDR,
  output logic             ARVALID,
  input  wire logic        ARREADY,
  input  wire logic [31:0] RDATA,
  input  wire logic [1:0]  RRESP,
  input  wire logic        RVALID,
  output logic             RREADY,
  // hang flag
  output logic             TIMEOUT
);
  logic [1:0] resp;

  initial begin
    {AWADDR, AWVALID, WDATA, WSTRB, WVALID, BREADY} = '0;
    {ARADDR, ARVALID, RREADY, TIMEOUT} = '0;
    resp = 2'h0;
  end

  // one byte per access, one port address
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a, w, b;
    b = 1'h0;
    @(posedge CLK);
    AWADDR  <= {idx, 2'h0};
    WDATA   <= {24'h0, d};
    WSTRB   <= 4'hF;
    AWVALID <= 1'h1;
    WVALID  <= 1'h1;
    BREADY  <= 1'h1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge CLK);
      a = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID;
      resp = BRESP;
      @(posedge CLK);
      if (a) AWVALID <= 1'h0;
      if (w) WVALID <= 1'h0;
      if (b) BREADY <= 1'h0;
    end
    if (!b) TIMEOUT <= 1'h1;
  endtask

  // read one byte of a port
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic a, r;
    r = 1'h0;
    d = 8'h00;
    @(posedge CLK);
    ARADDR  <= {idx, 2'h0};
    ARVALID <= 1'h1;
    RREADY  <= 1'h1;
    for (int n = 0; n < 40 && !r; n++) begin
      @(negedge CLK);
      a = ARVALID && ARREADY;
      r = RVALID;
      d = RDATA[7:0];
      resp = RRESP;
      @(posedge CLK);
      if (a) ARVALID <= 1'h0;
      if (r) RREADY <= 1'h0;
    end
    if (!r) TIMEOUT <= 1'h1;
  endtask
endmodule

// >>> dv/aes_block_cipher_unit_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
// ---------------------------------------------------------------
// bench top
// ---------------------------------------------------------------
module aes_block_cipher_unit_bench;
  import abc_pkg::*;
  localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] PT  = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  logic         ref_clk, resetn, irq, tmo;
  logic [9:0]   awaddr, araddr;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic [7:0]   v;
  logic [127:0] blk;
  logic [7:0]   regs [6];
  logic [2:0]   modes [4];
  int           n_mismatch, tests_run;

  initial ref_clk = 1'h0;
  always #12.5 ref_clk = ~ref_clk;

  abc_unit uut (
    .REF_CLK(ref_clk), .RESETN(resetn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CIPHER_DONE_IRQ(irq)
  );

  abc_mcu_model mcu (
    .CLK(ref_clk), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .TIMEOUT(tmo)
  );

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (tmo === 1'h1) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e,
                        input string nm);
    logic [7:0] d;
    mcu.rd(idx, d);
    `CHK(nm, e, d)
  endtask

  task automatic load(input logic [7:0] idx, input logic [127:0] val);
    for (int i = 0; i < 16; i++) mcu.wr(idx, val[127-8*i -: 8]);
  endtask

  task automatic fetch(output logic [127:0] val);
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      mcu.rd(DAT_IDX, d);
      val[127-8*i -: 8] = d;
    end
  endtask

  // one operation: mode, go, busy read, ignored write, completion
  task automatic run(input logic [2:0] m, input logic dec);
    int         n;
    logic [7:0] cs;
    cs = {3'h0, m, dec, 1'h0};
    n = 0;
    mcu.wr(CS_IDX, cs);
    mcu.wr(CS_IDX, cs | 8'h01);
    chk_rd(CS_IDX, cs | 8'h01, "busy");
    mcu.wr(DAT_IDX, 8'h5A);
    do begin
      @(negedge ref_clk);
      n++;
    end while (irq !== 1'h1 && n < 100);
    `CHK("latency", 38, n)
    if (n >= 100) conclude();
    @(negedge ref_clk);
    `CHK("irq pulse", 1'h0, irq)
    chk_rd(CS_IDX, cs, "go cleared");
  endtask

  initial begin
    resetn = 1'h0;
    n_mismatch = 0;
    tests_run = 0;
    regs = '{CS_IDX, PTR1_IDX, PTR2_IDX, KEY_IDX, IV_IDX, DAT_IDX};
    modes = '{M_CBC, M_CFB, M_OFB, M_CTR};
    repeat (10) @(posedge ref_clk);
    resetn <= 1'h1;
    foreach (regs[i]) chk_rd(regs[i], 8'h00, "reset");
    mcu.rd(8'h00, v);
    `CHK("unmapped rd", RESP_ERR, mcu.resp)
    mcu.wr(8'h01, 8'hFF);
    `CHK("unmapped wr", RESP_ERR, mcu.resp)
    mcu.wr(PTR1_IDX, 8'hA5);
    chk_rd(PTR1_IDX, 8'hA5, "ptr1");
    mcu.wr(PTR2_IDX, 8'hFF);
    chk_rd(PTR2_IDX, 8'h0F, "ptr2");
    mcu.wr(PTR1_IDX, 8'h00);
    mcu.wr(PTR2_IDX, 8'h00);
    $display("test registers done");
    // key, then data, then mode and go
    load(KEY_IDX, KEY);
    chk_rd(PTR1_IDX, 8'h00, "key wrap");
    load(DAT_IDX, PT);
    run(M_ECB, 1'h0);
    fetch(blk);
    `CHK("ecb enc", CT, blk)
    run(M_ECB, 1'h1);
    fetch(blk);
    `CHK("ecb dec", PT, blk)
    $display("test ecb done");
    mcu.wr(PTR2_IDX, 8'h03);
    mcu.wr(DAT_IDX, 8'hEE);
    chk_rd(PTR2_IDX, 8'h04, "ptr step");
    mcu.wr(PTR2_IDX, 8'h00);
    fetch(blk);
    `CHK("partial", {PT[127:104], 8'hEE, PT[95:0]}, blk)
    $display("test partial update done");
    foreach (modes[i]) begin
      load(IV_IDX, PT);
      load(DAT_IDX, 128'h0);
      run(modes[i], 1'h0);
      fetch(blk);
      `CHK("chain", CT, blk)
    end
    load(IV_IDX, PT);
    load(DAT_IDX, 128'h0);
    run(M_CBC, 1'h0);
    load(DAT_IDX, PT ^ CT);
    run(M_CBC, 1'h0);
    fetch(blk);
    `CHK("cbc second", CT, blk)
    foreach (modes[i]) begin
      load(IV_IDX, PT);
      load(DAT_IDX, CT);
      run(modes[i], 1'h1);
      fetch(blk);
      `CHK("chain dec", 128'h0, blk)
    end
    $display("test chaining done");
    load(IV_IDX, PT);
    load(DAT_IDX, 128'h0);
    run(M_CTR, 1'h0);
    fetch(blk);
    `CHK("ctr kept", 1'h0, blk === CT)
    mcu.wr(CS_IDX, {3'h0, M_ECB, 2'h0});
    load(IV_IDX, PT);
    load(DAT_IDX, 128'h0);
    run(M_CTR, 1'h0);
    fetch(blk);
    `CHK("ctr reload", CT, blk)
    $display("test counter done");
    conclude();
  end
endmodule

// >>> hw/abc_pkg.sv
package abc_pkg;

  // ---------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] CS_IDX   = 8'hE8;
  localparam logic [7:0] KEY_IDX  = 8'hF1;
  localparam logic [7:0] IV_IDX   = 8'hF2;
  localparam logic [7:0] DAT_IDX  = 8'hF3;
  localparam logic [7:0] PTR1_IDX = 8'hF5;
  localparam logic [7:0] PTR2_IDX = 8'hF6;

  // ---------------------------------------------------------------
  // control field positions and reset values
  // ---------------------------------------------------------------
  localparam int         CS_GO_BIT   = 0;
  localparam int         CS_DECR_BIT = 1;
  localparam int         CS_MODE_LSB = 2;
  localparam int         CS_MODE_MSB = 4;
  localparam int         KP_LSB      = 4;
  localparam logic [7:0] CS_RESET    = 8'h00;
  localparam logic [3:0] PTR_RESET   = 4'h0;

  // ---------------------------------------------------------------
  // chaining modes, plus ECB without chaining
  // ---------------------------------------------------------------
  localparam logic [2:0] M_CBC = 3'h0;
  localparam logic [2:0] M_CFB = 3'h1;
  localparam logic [2:0] M_OFB = 3'h2;
  localparam logic [2:0] M_CTR = 3'h3;
  localparam logic [2:0] M_ECB = 3'h4;

  // ---------------------------------------------------------------
  // cipher timing in clock cycles
  // ---------------------------------------------------------------
  localparam logic [5:0] OP_CYCLES = 6'h2D;
  localparam logic [5:0] OP_LAST   = OP_CYCLES - 6'h01;
  localparam logic [5:0] ROUNDS    = 6'h0A;
  localparam logic [5:0] DEC_LAST  = 6'h14;
  localparam logic [7:0] RCON_INIT = 8'h01;

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } abc_state_t;

endpackage

// >>> hw/abc_unit.sv
`timescale 1ns/1ps
module abc_unit
  import abc_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RESETN,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // completion
  output logic                   CIPHER_DONE_IRQ
);
  import abc_pkg::*;

  typedef struct packed {
    abc_state_t        st;
    logic [5:0]        cnt;
    logic [2:0]        mode;
    logic              decr;
    logic [127:0]      key;
    logic [127:0]      iv;
    logic [127:0]      dat;
    logic [127:0]      ctr;
    logic [127:0]      blk;
    logic [127:0]      rk;
    logic [7:0]        rcon;
    logic [3:0]        kp;
    logic [3:0]        vp;
    logic [3:0]        dp;
    logic              aw_ok;
    logic              w_ok;
    logic [ADDR_W-1:0] awa;
    logic [7:0]        wd;
    logic              wst;
    logic              bv;
    logic [1:0]        br;
    logic              rv;
    logic [7:0]        rd;
    logic [1:0]        rr;
    logic              irq;
  } abc_regs_t;

  abc_regs_t    r_reg;
  abc_regs_t    r_next;
  logic         busy;
  logic         core_dec;
  logic [127:0] core_in;
  logic         wr_now;
  logic [7:0]   widx;
  logic [7:0]   ridx;
  logic         fin;

  // ---------------------------------------------------------------
  // field arithmetic
  // ---------------------------------------------------------------
  function automatic logic [7:0] xt(input logic [7:0] x);
    return {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
  endfunction

  function automatic logic [7:0] ixt(input logic [7:0] x);
    return x[0] ? {1'b1, x[7:1] ^ 7'h0D} : {1'b0, x[7:1]};
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction

  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] y;
    y = x;
    for (int i = 0; i < 6; i++) y = gmul(gmul(y, y), x);
    return gmul(y, y);
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] v;
    v = ginv(x);
    return v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]}
           ^ {v[3:0], v[7:4]} ^ 8'h63;
  endfunction

  function automatic logic [7:0] isbox(input logic [7:0] y);
    return ginv({y[6:0], y[7]} ^ {y[4:0], y[7:5]} ^ {y[1:0], y[7:2]}
                ^ 8'h05);
  endfunction

  // ---------------------------------------------------------------
  // round steps, byte k = row + 4 * column from the top of the word
  // ---------------------------------------------------------------
  // state array placement
  function automatic logic [127:0] subshift(input logic [127:0] s,
                                            input logic        inv);
    logic [127:0] o;
    logic [7:0]   b;
    int           c;
    o = '0;
    for (int k = 0; k < 16; k++) begin
      c = inv ? ((k / 4) + 4 - (k % 4)) % 4 : ((k / 4) + (k % 4)) % 4;
      b = s[127 - 8 * ((k % 4) + 4 * c) -: 8];
      o[127 - 8 * k -: 8] = inv ? isbox(b) : sbox(b);
    end
    return o;
  endfunction

  function automatic logic [127:0] mix(input logic [127:0] s,
                                       input logic        inv);
    logic [127:0] o;
    logic [7:0]   a;
    logic [7:0]   c;
    o = '0;
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 4; i++) begin
        a = 8'h00;
        for (int m = 0; m < 4; m++) begin
          case ((m - i + 4) % 4)
            0:       c = inv ? 8'h0E : 8'h02;
            1:       c = inv ? 8'h0B : 8'h03;
            2:       c = inv ? 8'h0D : 8'h01;
            default: c = inv ? 8'h09 : 8'h01;
          endcase
          a = a ^ gmul(c, s[127 - 8 * (m + 4 * j) -: 8]);
        end
        o[127 - 8 * (i + 4 * j) -: 8] = a;
      end
    end
    return o;
  endfunction

  function automatic logic [31:0] subw(input logic [31:0] w);
    return {sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
  endfunction

  function automatic logic [127:0] kfwd(input logic [127:0] k,
                                        input logic [7:0]   rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w0 = k[127:96] ^ subw(k[31:0]) ^ {rc, 24'h000000};
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    w3 = k[31:0] ^ w2;
    return {w0, w1, w2, w3};
  endfunction

  function automatic logic [127:0] kbwd(input logic [127:0] k,
                                        input logic [7:0]   rc);
    logic [31:0] w3;
    w3 = k[31:0] ^ k[63:32];
    return {k[127:96] ^ subw(w3) ^ {rc, 24'h000000},
            k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], w3};
  endfunction

  // ---------------------------------------------------------------
  // mode steering
  // ---------------------------------------------------------------
  assign busy   = r_reg.st == ST_RUN;
  assign fin    = busy && r_reg.cnt == OP_LAST;
  assign wr_now = r_reg.aw_ok && r_reg.w_ok && r_reg.wst;
  assign widx   = r_reg.awa[9:2];
  assign ridx   = S_AXI_ARADDR[9:2];
  assign core_dec = r_reg.decr && r_reg.mode != M_CFB
                    && r_reg.mode != M_OFB && r_reg.mode != M_CTR;
  assign core_in = (r_reg.mode == M_CBC) ?
                     (r_reg.decr ? r_reg.dat : r_reg.dat ^ r_reg.iv) :
                   (r_reg.mode == M_CFB || r_reg.mode == M_OFB) ? r_reg.iv :
                   (r_reg.mode == M_CTR) ? r_reg.ctr : r_reg.dat;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [127:0] t;
    logic [127:0] k;
    logic [127:0] o;
    logic [7:0]   rc;
    t = '0;
    k = '0;
    o = '0;
    rc = 8'h00;
    r_next = r_reg;
    r_next.irq = 1'b0;
    case (r_reg.st)
      ST_RUN: begin
        r_next.cnt = r_reg.cnt + 6'h01;
        if (!core_dec) begin
          if (r_reg.cnt == 6'h00) begin
            r_next.blk  = core_in ^ r_reg.key;
            r_next.rk   = r_reg.key;
            r_next.rcon = RCON_INIT;
          end else if (r_reg.cnt <= ROUNDS) begin
            t = subshift(r_reg.blk, 1'b0);
            if (r_reg.cnt != ROUNDS) t = mix(t, 1'b0);
            k = kfwd(r_reg.rk, r_reg.rcon);
            r_next.blk  = t ^ k;
            r_next.rk   = k;
            r_next.rcon = xt(r_reg.rcon);
          end
        end else if (r_reg.cnt < ROUNDS) begin
          rc = (r_reg.cnt == 6'h00) ? RCON_INIT : r_reg.rcon;
          r_next.rk   = kfwd((r_reg.cnt == 6'h00) ? r_reg.key : r_reg.rk, rc);
          r_next.rcon = xt(rc);
        end else if (r_reg.cnt == ROUNDS) begin
          r_next.blk = core_in ^ r_reg.rk;
        end else if (r_reg.cnt <= DEC_LAST) begin
          rc = ixt(r_reg.rcon);
          k  = kbwd(r_reg.rk, rc);
          t  = subshift(r_reg.blk, 1'b1) ^ k;
          if (r_reg.cnt != DEC_LAST) t = mix(t, 1'b1);
          r_next.blk  = t;
          r_next.rk   = k;
          r_next.rcon = rc;
        end
        if (fin) begin
          o = r_reg.blk;
          r_next.st  = ST_IDLE;
          r_next.irq = 1'b1;
          case (r_reg.mode)
            M_CBC: begin
              r_next.dat = r_reg.decr ? o ^ r_reg.iv : o;
              r_next.iv  = r_reg.decr ? r_reg.dat : o;
            end
            M_CFB: begin
              r_next.dat = r_reg.dat ^ o;
              r_next.iv  = r_reg.decr ? r_reg.dat : r_reg.dat ^ o;
            end
            M_OFB: begin
              r_next.dat = r_reg.dat ^ o;
              r_next.iv  = o;
            end
            M_CTR: begin
              r_next.dat = r_reg.dat ^ o;
              r_next.ctr = r_reg.ctr + 128'h1;
            end
            default: r_next.dat = o;
          endcase
        end
      end
      default: r_next.cnt = 6'h00;
    endcase

    // bus write channels
    if (!r_reg.aw_ok && !r_reg.bv && S_AXI_AWVALID) begin
      r_next.aw_ok = 1'b1;
      r_next.awa   = S_AXI_AWADDR;
    end
    if (!r_reg.w_ok && !r_reg.bv && S_AXI_WVALID) begin
      r_next.w_ok = 1'b1;
      r_next.wd   = S_AXI_WDATA[7:0];
      r_next.wst  = S_AXI_WSTRB[0];
    end
    if (r_reg.bv && S_AXI_BREADY) r_next.bv = 1'b0;
    if (r_reg.aw_ok && r_reg.w_ok) begin
      r_next.aw_ok = 1'b0;
      r_next.w_ok  = 1'b0;
      r_next.bv    = 1'b1;
      r_next.br    = RESP_OK;
      case (widx)
        CS_IDX, KEY_IDX, IV_IDX, DAT_IDX, PTR1_IDX, PTR2_IDX: ;
        default: r_next.br = RESP_ERR;
      endcase
      if (r_reg.wst && !busy) begin
        case (widx)
          CS_IDX: begin
            if (r_reg.wd[CS_MODE_MSB:CS_MODE_LSB] == M_CTR
                && r_reg.mode != M_CTR) r_next.ctr = r_reg.iv;
            r_next.mode = r_reg.wd[CS_MODE_MSB:CS_MODE_LSB];
            r_next.decr = r_reg.wd[CS_DECR_BIT];
            if (r_reg.wd[CS_GO_BIT]) r_next.st = ST_RUN;
          end
          KEY_IDX: begin
            r_next.key[{~r_reg.kp, 3'h0} +: 8] = r_reg.wd;
            r_next.kp = r_reg.kp + 4'h1;
          end
          IV_IDX: begin
            r_next.iv[{~r_reg.vp, 3'h0} +: 8] = r_reg.wd;
            r_next.vp = r_reg.vp + 4'h1;
          end
          DAT_IDX: begin
            r_next.dat[{~r_reg.dp, 3'h0} +: 8] = r_reg.wd;
            r_next.dp = r_reg.dp + 4'h1;
          end
          PTR1_IDX: begin
            r_next.kp = r_reg.wd[7:KP_LSB];
            r_next.vp = r_reg.wd[3:0];
          end
          PTR2_IDX: r_next.dp = r_reg.wd[3:0];
          default: ;
        endcase
      end
    end

    // bus read channel
    if (r_reg.rv && S_AXI_RREADY) r_next.rv = 1'b0;
    if (!r_reg.rv && S_AXI_ARVALID) begin
      r_next.rv = 1'b1;
      r_next.rr = RESP_OK;
      r_next.rd = 8'h00;
      case (ridx)
        CS_IDX:   r_next.rd = {3'h0, r_reg.mode, r_reg.decr, busy};
        KEY_IDX: begin
          r_next.rd = r_next.key[{~r_next.kp, 3'h0} +: 8];
          r_next.kp = r_next.kp + 4'h1;
        end
        IV_IDX: begin
          r_next.rd = r_next.iv[{~r_next.vp, 3'h0} +: 8];
          r_next.vp = r_next.vp + 4'h1;
        end
        DAT_IDX: begin
          r_next.rd = r_next.dat[{~r_next.dp, 3'h0} +: 8];
          r_next.dp = r_next.dp + 4'h1;
        end
        PTR1_IDX: r_next.rd = {r_next.kp, r_next.vp};
        PTR2_IDX: r_next.rd = {4'h0, r_next.dp};
        default:  r_next.rr = RESP_ERR;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      r_reg    <= '0;
      r_reg.st <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign S_AXI_AWREADY   = !r_reg.aw_ok && !r_reg.bv;
  assign S_AXI_WREADY    = !r_reg.w_ok && !r_reg.bv;
  assign S_AXI_BVALID    = r_reg.bv;
  assign S_AXI_BRESP     = r_reg.br;
  assign S_AXI_ARREADY   = !r_reg.rv;
  assign S_AXI_RVALID    = r_reg.rv;
  assign S_AXI_RRESP     = r_reg.rr;
  assign S_AXI_RDATA     = {24'h000000, r_reg.rd};
  assign CIPHER_DONE_IRQ = r_reg.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  property p_len;
    $rose(busy) |-> ##44 busy ##1 !busy;
  endproperty
  a_len: assert property (p_len) else $error("busy length wrong");

  property p_irq;
    $fell(busy) |-> CIPHER_DONE_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("no done irq");

  property p_go;
    wr_now && widx == CS_IDX && r_reg.wd[0] && !busy |=> busy;
  endproperty
  a_go: assert property (p_go) else $error("go did not start");

  property p_ctr_load;
    wr_now && !busy && widx == CS_IDX && r_reg.mode != M_CTR
      && r_reg.wd[4:2] == M_CTR |=> r_reg.ctr == $past(r_reg.iv);
  endproperty
  a_ctr_load: assert property (p_ctr_load) else $error("ctr stale");

  property p_ctr_hold;
    r_reg.mode == M_CTR && !fin |=> $stable(r_reg.ctr);
  endproperty
  a_ctr_hold: assert property (p_ctr_hold) else $error("ctr reloaded");

  property p_kptr;
    wr_now && !busy && widx == KEY_IDX && !S_AXI_ARVALID
      |=> r_reg.kp == 4'($past(r_reg.kp) + 4'h1);
  endproperty
  a_kptr: assert property (p_kptr) else $error("key pointer stuck");

  property p_freeze;
    busy && wr_now && widx == KEY_IDX |=> $stable(r_reg.key);
  endproperty
  a_freeze: assert property (p_freeze) else $error("busy key write");

  property p_cfb_enc;
    fin && r_reg.mode == M_CFB
      |=> r_reg.iv == (r_reg.decr ? $past(r_reg.dat) : r_reg.dat);
  endproperty
  a_cfb_enc: assert property (p_cfb_enc) else $error("cfb feedback");

  property p_cbc;
    fin && r_reg.mode == M_CBC && !r_reg.decr |=> r_reg.iv == r_reg.dat;
  endproperty
  a_cbc: assert property (p_cbc) else $error("cbc chain wrong");

  property p_ofb;
    fin && r_reg.mode == M_OFB |=> r_reg.iv == (r_reg.dat ^ $past(r_reg.dat));
  endproperty
  a_ofb: assert property (p_ofb) else $error("ofb feedback wrong");

  c_ecb: cover property (fin && r_reg.mode == M_ECB);
  c_dec: cover property (fin && r_reg.mode == M_CBC && r_reg.decr);
  c_ctr: cover property (fin && r_reg.mode == M_CTR);

endmodule
